// ---- rtl/nic_bus_dma.sv ----
// Host register port and bus master DMA engine of the network controller
//
// Function
// - Acknowledge only after synchronised select and strobe
// - Acknowledge waits for running DMA to finish
// - Acknowledge timed from the later of select, strobe
// - Select decoded when acknowledge is asserted
// - Address strobe high passes, falling edge latches
// - Late grant slips DMA start four clocks
// - Remote one transfer per tenure, local bursts
// - Extra address cycles only before first transfer
// - Upper address held through byte burst
// - Ready sampled at T3, waits while low
// - Port request after port strobe, drop after ack returns high
// - Next remote after ack, local served first
// - Request on clock edge, strobes only granted
// - Address strobed before memory read strobe
`timescale 1ns/100ps
`include "nic_dma_defs.svh"
module nic_bus_dma (
  input  wire logic                mclk_in,              // Bus clock
  input  wire logic                sys_rst_in,           // Async reset, high
  input  wire logic                clk_en_in,            // Clock enable
  input  wire logic                cs_n_in,              // Chip select, low
  input  wire logic                slave_read_n_in,      // Register read strobe, low
  input  wire logic                slave_write_n_in,     // Register write strobe, low
  input  wire logic [`RSEL_W-1:0]  reg_select_in,        // Register select lines
  input  wire logic                addr_strobe0_in,      // Select latch strobe
  output logic                     ack_n_out,            // Slave acknowledge, low
  output logic      [`RSEL_W-1:0]  reg_index_out,        // Decoded register index
  output logic                     reg_rd_out,           // Register read pulse
  output logic                     reg_wr_out,           // Register write pulse
  input  wire logic                local_req_in,         // FIFO wants local DMA
  input  wire logic [`BURST_W-1:0] burst_len_in,         // Local burst length, 0 = 16
  input  wire logic                local_load_in,        // Load local address
  input  wire logic [`DATA_W-1:0]  local_addr_in,        // Local start address
  input  wire logic                remote_start_in,      // Start remote read
  input  wire logic [`DATA_W-1:0]  remote_addr_in,       // Remote start address
  input  wire logic [`DATA_W-1:0]  remote_count_in,      // Remote transfers
  input  wire logic                mode_word_in,         // Word transfers
  input  wire logic                mode_32bit_in,        // 32-bit addressing
  input  wire logic [`DATA_W-1:0]  ext_addr_in,          // Upper address word
  output logic                     bus_req_out,          // Bus request
  input  wire logic                bus_grant_in,         // Bus grant
  output logic                     ctrl_oe_out,          // Bus strobes driven
  output logic                     addr_strobe0_out,     // Address strobe
  output logic                     addr_strobe1_out,     // Upper address strobe
  output logic                     mem_read_n_out,       // Memory read, low
  input  wire logic                ready_in,             // Memory ready, low waits
  output logic      [`DATA_W-1:0]  muxed_addr_data_out,  // Address lines out
  output logic                     muxed_addr_data_oe_out, // Address lines driven
  output logic                     upper_addr_oe_out,    // Upper address driven
  input  wire logic [`DATA_W-1:0]  muxed_addr_data_in,   // Memory read data
  output logic                     port_req_out,         // Port request
  output logic                     port_write_n_out,     // Port write strobe, low
  output logic      [`DATA_W-1:0]  port_data_out,        // Word for I/O port
  input  wire logic                remote_read_ack_n_in, // Remote read ack, low
  output logic      [`DATA_W-1:0]  net_data_out,         // FIFO data to network
  output logic                     net_valid_out,        // FIFO data valid
  input  wire logic                net_ready_in          // Network takes word
);
  import nic_dma_pkg::*;

  dma_st_t                st_q, st_d;
  port_st_t               pst_q, pst_d;
  logic                   acc_s1_q, acc_s2_q, ack_q, ack_done_q;
  logic [`RSEL_W-1:0]     reg_index_q;
  logic                   reg_rd_q, reg_wr_q;
  logic [`RSEL_W-1:0]     sel_w;
  logic                   access_w, ack_set_w, slave_wait_w;
  logic                   sel_local_q, sel_local_d;
  logic [2:0]             slip_q;
  logic [`BURST_W-1:0]    beats_q;
  logic [`DATA_W-1:0]     lcl_addr_q, rem_addr_q, rem_cnt_q, ad_q;
  logic                   upper_oe_q;
  logic                   fifo_ready_w, local_go_w, rem_go_w;
  logic                   take_w, push_w, more_w;
  logic [`DATA_W-1:0]     cur_addr_w;

  // Address step for the selected transfer width
  function automatic logic [`DATA_W-1:0] next_addr(input logic [`DATA_W-1:0] a, input logic word);
    next_addr = a + (word ? `ADDR_STEP_WORD : `ADDR_STEP_BYTE);
  endfunction : next_addr

  regsel_latch u_sel (
    .clk_in    (mclk_in),
    .rst_in    (sys_rst_in),
    .en_in     (clk_en_in),
    .strobe_in (addr_strobe0_in),
    .sel_in    (reg_select_in),
    .sel_out   (sel_w)
  );

  // Full FIFO stalls the memory read in T3, so no word is dropped
  stream_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clk_in        (mclk_in),
    .rst_in        (sys_rst_in),
    .en_in         (clk_en_in),
    .in_valid_in   (push_w),
    .in_ready_out  (fifo_ready_w),
    .in_data_in    (muxed_addr_data_in),
    .out_valid_out (net_valid_out),
    .out_ready_in  (net_ready_in),
    .out_data_out  (net_data_out)
  );

  // Slave access is live once both select and strobe are low
  assign access_w     = ~cs_n_in & (~slave_read_n_in | ~slave_write_n_in);
  assign slave_wait_w = acc_s2_q & ~ack_done_q;
  assign ack_set_w    = acc_s2_q & access_w & ~ack_done_q & (st_q == ST_IDLE);
  assign ack_n_out     = ~ack_q;
  assign reg_index_out = reg_index_q;
  assign reg_rd_out    = reg_rd_q;
  assign reg_wr_out    = reg_wr_q;

  // Slave synchroniser and acknowledge; ack holds until the strobe lifts
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      acc_s1_q    <= 1'b0;
      acc_s2_q    <= 1'b0;
      ack_q       <= 1'b0;
      ack_done_q  <= 1'b0;
      reg_index_q <= `SEL_RESET;
      reg_rd_q    <= 1'b0;
      reg_wr_q    <= 1'b0;
    end else if (clk_en_in) begin
      acc_s1_q   <= access_w;
      acc_s2_q   <= acc_s1_q;
      ack_q      <= ack_set_w | (ack_q & access_w);
      ack_done_q <= (ack_done_q | ack_set_w) & acc_s2_q;
      reg_rd_q   <= ack_set_w & ~slave_read_n_in;
      reg_wr_q   <= ack_set_w & ~slave_write_n_in;
      if (ack_set_w) begin
        reg_index_q <= sel_w;
      end
    end
  end

  // Pending work; a waiting register access holds off new tenures
  assign local_go_w = local_req_in & fifo_ready_w & ~slave_wait_w;
  assign rem_go_w   = (rem_cnt_q != '0) & (pst_q == P_IDLE) & ~slave_wait_w;
  assign cur_addr_w = sel_local_q ? lcl_addr_q : rem_addr_q;
  assign take_w     = (st_q == ST_T3) & ready_in & (~sel_local_q | fifo_ready_w);
  assign push_w     = take_w & sel_local_q;
  assign more_w     = sel_local_q & local_req_in & fifo_ready_w & (beats_q != burst_len_in);

  // Bus cycle sequencer
  always_comb begin
    st_d        = st_q;
    sel_local_d = sel_local_q;
    unique case (st_q)
      ST_IDLE: begin
        if (local_go_w) begin
          st_d        = ST_REQ;
          sel_local_d = 1'b1;
        end else if (rem_go_w) begin
          st_d        = ST_REQ;
          sel_local_d = 1'b0;
        end
      end
      ST_REQ: begin
        if (!bus_grant_in) begin
          st_d = ST_SLIP;
        end else if (mode_32bit_in) begin
          st_d = ST_X1;
        end else begin
          st_d = ST_T1;
        end
      end
      ST_SLIP: begin
        if (slip_q == 3'h0) st_d = ST_REQ;
      end
      ST_X1:   st_d = ST_X2;
      ST_X2:   st_d = ST_X3;
      ST_X3:   st_d = ST_X4;
      ST_X4:   st_d = ST_T1;
      ST_T1:   st_d = ST_T2;
      ST_T2:   st_d = ST_T3;
      ST_T3: begin
        if (take_w) st_d = ST_T4;
      end
      ST_T4: begin
        st_d = more_w ? ST_T1 : ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Bus signals decoded from the state flops
  assign bus_req_out            = (st_q != ST_IDLE);
  assign ctrl_oe_out            = bus_req_out & (st_q != ST_REQ) & (st_q != ST_SLIP);
  assign addr_strobe0_out       = (st_q == ST_T1);
  assign addr_strobe1_out       = (st_q == ST_X1);
  assign mem_read_n_out         = ~((st_q == ST_T2) | (st_q == ST_T3));
  assign muxed_addr_data_out    = ad_q;
  assign muxed_addr_data_oe_out = (st_q == ST_T1) | (st_q == ST_X1) | (st_q == ST_X2);
  assign upper_addr_oe_out      = mode_word_in ? muxed_addr_data_oe_out : upper_oe_q;

  // Sequencer state, grant slip count and address phase register
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q        <= ST_IDLE;
      sel_local_q <= 1'b0;
      slip_q      <= 3'h0;
      ad_q        <= '0;
      upper_oe_q  <= 1'b0;
    end else if (clk_en_in) begin
      st_q        <= st_d;
      sel_local_q <= sel_local_d;
      if (st_d == ST_SLIP && st_q == ST_REQ) slip_q <= 3'(`SLIP_CYCLES - 1);
      else if (st_q == ST_SLIP) slip_q <= slip_q - 3'h1;
      if (st_d == ST_X1) ad_q <= ext_addr_in;
      else if (st_d == ST_T1) ad_q <= cur_addr_w;
      // Byte mode keeps upper address out until the burst ends
      upper_oe_q  <= (upper_oe_q | (st_d == ST_T1)) & (st_d != ST_IDLE);
    end
  end

  // Address and transfer counters
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lcl_addr_q <= '0;
      rem_addr_q <= '0;
      rem_cnt_q  <= '0;
      beats_q    <= '0;
    end else if (clk_en_in) begin
      if (local_load_in) lcl_addr_q <= local_addr_in;
      else if (push_w) lcl_addr_q <= next_addr(lcl_addr_q, mode_word_in);
      if (remote_start_in) begin
        rem_addr_q <= remote_addr_in;
        rem_cnt_q  <= remote_count_in;
      end else if (take_w && !sel_local_q) begin
        rem_addr_q <= next_addr(rem_addr_q, mode_word_in);
        rem_cnt_q  <= rem_cnt_q - 16'h0001;
      end
      if (st_q == ST_REQ) beats_q <= '0;
      else if (push_w) beats_q <= beats_q + 4'h1;
    end
  end

  // Remote port handshake: strobe, gap, then request until ack returns high
  always_comb begin
    pst_d = pst_q;
    unique case (pst_q)
      P_IDLE: if (take_w && !sel_local_q) pst_d = P_STB;
      P_STB:  pst_d = P_GAP;
      P_GAP:  pst_d = P_REQ;
      P_REQ:  if (!remote_read_ack_n_in) pst_d = P_IDLE;
    endcase
  end

  // Request stays up through the low ack pulse and drops once ack is high
  logic ack_seen_q;
  assign port_write_n_out = (pst_q != P_STB);
  assign port_req_out     = (pst_q == P_REQ) | ack_seen_q;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pst_q         <= P_IDLE;
      ack_seen_q    <= 1'b0;
      port_data_out <= '0;
    end else if (clk_en_in) begin
      pst_q      <= pst_d;
      ack_seen_q <= ((pst_q == P_REQ) | ack_seen_q) & ~remote_read_ack_n_in;
      if (take_w && !sel_local_q) port_data_out <= muxed_addr_data_in;
    end
  end

  // Checks on the protocol, sampled only on enabled edges
  default clocking cb @(posedge mclk_in iff clk_en_in); endclocking
  default disable iff (sys_rst_in);

  ack_sync_wait_a: assert property ($rose(ack_q) |-> $past(access_w) && $past(access_w, 2))
    else $error("ack rose without a synchronised access");
  ack_dma_idle_a: assert property ($rose(ack_q) |-> $past(st_q) == ST_IDLE)
    else $error("ack rose during a DMA tenure");
  idx_at_ack_a: assert property ($rose(ack_q) |-> reg_index_q == $past(sel_w))
    else $error("register index not taken at ack");
  sel_flow_a: assert property (addr_strobe0_in |-> sel_w == reg_select_in)
    else $error("select not transparent with strobe high");
  grant_slip_a: assert property (st_q == ST_REQ && !bus_grant_in |=> (st_q == ST_SLIP) [*4] ##1 st_q == ST_REQ)
    else $error("late grant did not slip four clocks");
  remote_single_a: assert property (st_q == ST_T4 && !sel_local_q |=> st_q == ST_IDLE)
    else $error("remote tenure held more than one transfer");
  ext_once_a: assert property (st_q == ST_T4 |=> st_q != ST_X1)
    else $error("extra address cycles inside a burst");
  upper_hold_a: assert property (upper_oe_q && st_q != ST_IDLE |=> upper_oe_q || st_q == ST_IDLE)
    else $error("upper address released mid burst");
  wait_state_a: assert property (st_q == ST_T3 && !ready_in |=> st_q == ST_T3 && !mem_read_n_out)
    else $error("wait state not inserted");
  port_req_a: assert property ($rose(port_req_out) |-> port_write_n_out && $past(!port_write_n_out, 2))
    else $error("port request not after port write");
  port_drop_a: assert property (port_req_out && remote_read_ack_n_in && $past(!remote_read_ack_n_in)
                                |=> !port_req_out)
    else $error("port request not dropped after ack");
  local_first_a: assert property (st_q == ST_IDLE && local_go_w && rem_go_w |=> sel_local_q)
    else $error("remote served ahead of local");
  strobe_grant_a: assert property (!mem_read_n_out |-> ctrl_oe_out && bus_req_out)
    else $error("strobe driven without tenure");
  addr_first_a: assert property ($fell(mem_read_n_out) |-> $past(addr_strobe0_out))
    else $error("read strobe not preceded by address strobe");
  ack_release_a: assert property (ack_q && !access_w |=> !ack_q)
    else $error("ack held after strobe removed");

  burst_cov_c: cover property (st_q == ST_T4 ##1 st_q == ST_T1);
  remote_cov_c: cover property (pst_q == P_REQ ##1 ack_seen_q ##[1:20] !port_req_out);
  slip_cov_c: cover property (st_q == ST_SLIP ##4 st_q == ST_REQ);
  wide_cov_c: cover property (st_q == ST_X4 ##1 st_q == ST_T1);
endmodule : nic_bus_dma

// ---- rtl/nic_dma_defs.svh ----
// Offsets, field widths, reset values and timing counts of the host bus and DMA block
`ifndef NIC_DMA_DEFS_SVH
`define NIC_DMA_DEFS_SVH
`define DATA_W         16
`define RSEL_W         4
`define BURST_W        4
`define FIFO_DEPTH     4
`define SLIP_CYCLES    4
`define ADDR_STEP_BYTE 16'h0001
`define ADDR_STEP_WORD 16'h0002
`define SEL_RESET      4'h0
`endif

// ---- rtl/nic_dma_pkg.sv ----
// Types shared by the host bus and DMA block
package nic_dma_pkg;
  // Bus cycle states, Gray coded along T1'..T4', T1..T4
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_REQ  = 4'h1,
    ST_X1   = 4'h3,
    ST_X2   = 4'h2,
    ST_X3   = 4'h6,
    ST_X4   = 4'h7,
    ST_T1   = 4'h5,
    ST_T2   = 4'h4,
    ST_T3   = 4'hC,
    ST_T4   = 4'hD,
    ST_SLIP = 4'h9
  } dma_st_t;
  // Remote port handshake states
  typedef enum logic [1:0] {
    P_IDLE = 2'h0,
    P_STB  = 2'h1,
    P_GAP  = 2'h3,
    P_REQ  = 2'h2
  } port_st_t;
endpackage : nic_dma_pkg

// ---- rtl/regsel_latch.sv ----
// Register select latch: transparent while the strobe is high, captures on its fall
`timescale 1ns/100ps
`include "nic_dma_defs.svh"
module regsel_latch (
  input  wire logic               clk_in,     // Bus clock
  input  wire logic               rst_in,     // Async reset, high
  input  wire logic               en_in,      // Clock enable
  input  wire logic               strobe_in,  // Address strobe, low pulse latches
  input  wire logic [`RSEL_W-1:0] sel_in,     // Raw select lines
  output logic      [`RSEL_W-1:0] sel_out     // Effective select
);
  logic               prev_q;
  logic [`RSEL_W-1:0] held_q;
  logic               fell_w;

  // Falling strobe captures, high strobe flows through
  assign fell_w  = prev_q & ~strobe_in;
  assign sel_out = (strobe_in | fell_w) ? sel_in : held_q;

  // Strobe history and held select
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= 1'b1;
      held_q <= `SEL_RESET;
    end else if (en_in) begin
      prev_q <= strobe_in;
      if (fell_w) begin
        held_q <= sel_in;
      end
    end
  end
endmodule : regsel_latch

// ---- rtl/stream_fifo.sv ----
// Small valid/ready FIFO between memory reads and the network side
`timescale 1ns/100ps
module stream_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,        // Clock
  input  wire logic             rst_in,        // Async reset, high
  input  wire logic             en_in,         // Clock enable
  input  wire logic             in_valid_in,   // Write request
  output logic                  in_ready_out,  // Room for a word
  input  wire logic [WIDTH-1:0] in_data_in,    // Write data
  output logic                  out_valid_out, // Word available
  input  wire logic             out_ready_in,  // Reader takes word
  output logic      [WIDTH-1:0] out_data_out   // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push_w;
  logic             pop_w;

  // Honest full and empty from the fill count
  assign in_ready_out  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid_out = cnt_q != '0;
  assign push_w        = in_valid_in & in_ready_out;
  assign pop_w         = out_valid_out & out_ready_in;
  assign out_data_out  = mem_q[rd_q];

  // Storage needs no reset; emptiness comes from the count
  always_ff @(posedge clk_in) begin
    if (en_in && push_w) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (en_in) begin
      if (push_w) wr_q <= AW'(wr_q + 1'b1);
      if (pop_w) rd_q <= AW'(rd_q + 1'b1);
      cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w});
    end
  end
endmodule : stream_fifo

// ---- verification/nic_far_side.sv ----
// Far side model: bus arbiter, buffer memory and I/O port reader
`timescale 1ns/100ps
module nic_far_side (
  input  wire logic        clk_in,    // Bus clock
  input  wire logic        rst_in,    // Reset, high
  input  wire logic        req_in,    // Bus request
  input  wire logic        as_in,     // Address strobe
  input  wire logic [15:0] ad_in,     // Address lines
  input  wire logic        rd_n_in,   // Memory read, low
  input  wire logic        preq_in,   // Port request
  input  wire logic [3:0]  gdly_in,   // Grant latency
  input  wire logic [1:0]  wait_in,   // Wait states per cycle
  output logic             grant_out, // Bus grant
  output logic             ready_out, // Memory ready
  output logic      [15:0] data_out,  // Read data
  output logic             remote_read_ack_n_n_out // Remote read ack, low
);
  logic [15:0] addr_q, last_q;
  logic [3:0]  gcnt_q, rcnt_q, gap_q;
  logic [2:0]  wcnt_q;
  logic        gnt_q, done_q;
  // Grant after the latency; a late one forces a slip
  assign grant_out = req_in && (gcnt_q >= gdly_in);
  // Few waits, kept inside the throughput limit
  assign ready_out = (wcnt_q > {1'b0, wait_in});
  // Released lines show the inverse of the last word
  assign data_out = rd_n_in ? ~last_q : (addr_q ^ 16'h5A3C);
  // One ack pulse per request, and a long high gap between
  assign remote_read_ack_n_n_out = !(preq_in && !done_q && rcnt_q >= 4'h3 && gap_q >= 4'h7);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      {addr_q, last_q, gcnt_q, rcnt_q, gap_q, wcnt_q, gnt_q, done_q} <= '0;
    end else begin
      gcnt_q <= req_in ? gcnt_q + {3'h0, gcnt_q != 4'hF} : (gnt_q ? 4'h0 : gcnt_q);
      gnt_q  <= req_in && (gnt_q || grant_out);
      wcnt_q <= rd_n_in ? 3'h0 : wcnt_q + {2'h0, wcnt_q != 3'h7};
      addr_q <= as_in ? ad_in : addr_q;
      last_q <= rd_n_in ? last_q : data_out;
      rcnt_q <= (preq_in && !done_q) ? rcnt_q + {3'h0, rcnt_q != 4'hF} : 4'h0;
      done_q <= preq_in && (done_q || !remote_read_ack_n_n_out);
      gap_q  <= !remote_read_ack_n_n_out ? 4'h0 : gap_q + {3'h0, gap_q != 4'hF};
    end
  end
endmodule : nic_far_side

// ---- verification/nic_host_bus_and_dma_interface_test.sv ----
// Self-checking bench for the host bus and DMA block
`timescale 1ns/100ps
`include "nic_dma_defs.svh"
module nic_host_bus_and_dma_interface_test;
  logic mclk_in, sys_rst_in, cs_n_in, slave_read_n_in, slave_write_n_in, addr_strobe0_in, ack_n_out;
  logic reg_rd_out, reg_wr_out, local_req_in, local_load_in, remote_start_in, mode_word_in, mode_32bit_in;
  logic bus_req_out, bus_grant_in, ready_in, mem_read_n_out, port_req_out, port_write_n_out;
  logic remote_read_ack_n_in, net_valid_out, net_ready_in, addr_strobe0_out, up_oe, ctrl_oe, as1, ad_oe;
  logic [3:0]  reg_select_in, reg_index_out, burst_len_in, gdly;
  logic [1:0]  wt;
  logic [15:0] local_addr_in, remote_addr_in, remote_count_in, ext_addr_in, muxed_addr_data_in;
  logic [15:0] muxed_addr_data_out, port_data_out, net_data_out;
  logic [15:0] net_q[$], port_q[$];
  logic [5:0]  reg_q[$];
  logic [31:0] seed;
  int          error_cnt, checks;
  nic_bus_dma dut (.mclk_in, .sys_rst_in, .clk_en_in(1'b1), .cs_n_in, .slave_read_n_in, .slave_write_n_in,
    .reg_select_in, .addr_strobe0_in, .ack_n_out, .reg_index_out, .reg_rd_out, .reg_wr_out, .local_req_in,
    .burst_len_in, .local_load_in, .local_addr_in, .remote_start_in, .remote_addr_in, .remote_count_in,
    .mode_word_in, .mode_32bit_in, .ext_addr_in, .bus_req_out, .bus_grant_in, .ctrl_oe_out(ctrl_oe),
    .addr_strobe0_out, .addr_strobe1_out(as1), .mem_read_n_out, .ready_in, .muxed_addr_data_out,
    .muxed_addr_data_oe_out(ad_oe), .upper_addr_oe_out(up_oe), .muxed_addr_data_in, .port_req_out,
    .port_write_n_out, .port_data_out, .remote_read_ack_n_in, .net_data_out, .net_valid_out, .net_ready_in);
  nic_far_side far (.clk_in(mclk_in), .rst_in(sys_rst_in), .req_in(bus_req_out), .as_in(addr_strobe0_out),
    .ad_in(muxed_addr_data_out), .rd_n_in(mem_read_n_out), .preq_in(port_req_out), .gdly_in(gdly),
    .wait_in(wt), .grant_out(bus_grant_in), .ready_out(ready_in), .data_out(muxed_addr_data_in),
    .remote_read_ack_n_n_out(remote_read_ack_n_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_reg(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: strobe and index %h, wanted %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic give_verdict;
    $display("counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // Register access; a late select or a latched select on request
  task automatic reg_acc(input logic wr, input logic [3:0] sel, input logic late, input logic latch);
    int n;
    n = 0;
    @(posedge mclk_in) reg_select_in <= sel;
    addr_strobe0_in <= !latch;
    @(posedge mclk_in) reg_select_in <= latch ? ~sel : sel;
    reg_q.push_back({!wr, wr, sel});
    if (wr) slave_write_n_in <= 1'b0;
    else slave_read_n_in <= 1'b0;
    cs_n_in <= late;
    if (late) begin
      repeat (4) @(posedge mclk_in);
      chk_word({15'h0, ack_n_out}, 16'h1);
      cs_n_in <= 1'b0;
    end
    do begin @(posedge mclk_in); #1; n++; end while (ack_n_out !== 1'b0 && n < 300);
    chk_word({15'h0, n >= 3 && ack_n_out === 1'b0}, 16'h1);
    @(posedge mclk_in) {cs_n_in, slave_read_n_in, slave_write_n_in, addr_strobe0_in} <= 4'hF;
    repeat (3) @(posedge mclk_in);
    chk_word({15'h0, ack_n_out}, 16'h1);
  endtask : reg_acc
  // Clock is fast in time only; the logic counts cycles, not nanoseconds
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // Expected-result monitor; an empty queue never matches, unknowns included
  always @(posedge mclk_in) if (sys_rst_in === 1'b0) begin
    if ((reg_rd_out | reg_wr_out) === 1'b1)
      chk_reg({reg_rd_out, reg_wr_out, reg_index_out}, reg_q.size() ? reg_q.pop_front() : 6'h3F);
    if ((net_valid_out & net_ready_in) === 1'b1)
      chk_word(net_data_out, net_q.size() ? net_q.pop_front() : 16'(net_data_out === 16'h0));
    if (port_write_n_out === 1'b0)
      chk_word(port_data_out, port_q.size() ? port_q.pop_front() : 16'(port_data_out === 16'h0));
    if (ack_n_out === 1'b0) chk_word({15'h0, bus_req_out}, 16'h0);
    if (mem_read_n_out === 1'b0) chk_word({14'h0, ctrl_oe, up_oe}, {14'h0, 1'b1, !mode_word_in});
    if ((addr_strobe0_out | as1) === 1'b1) chk_word({15'h0, ad_oe}, 16'h1);
    if (as1 === 1'b1) chk_word(muxed_addr_data_out, ext_addr_in);
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    error_cnt++;
    give_verdict();
  end
  // Main sequence
  initial begin
    int n;
    {cs_n_in, slave_read_n_in, slave_write_n_in, addr_strobe0_in, sys_rst_in} = 5'h1F;
    {local_req_in, local_load_in, remote_start_in, mode_word_in, mode_32bit_in, net_ready_in} = 6'h0;
    {reg_select_in, burst_len_in, gdly, wt} = 14'h0;
    {local_addr_in, remote_addr_in, remote_count_in, ext_addr_in} = 64'h0;
    seed = 32'd84080;
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    reg_acc(1'b0, seed[5:2], 1'b0, 1'b0);
    $display("test transparent read done");
    reg_acc(1'b1, 4'h9, 1'b1, 1'b1);
    $display("test latched late-select write done");
    // Local burst into a stalled FIFO, a register read held off meanwhile
    @(posedge mclk_in) {local_addr_in, local_load_in, burst_len_in, mode_word_in, mode_32bit_in} <= {16'h0100, 7'h67};
    ext_addr_in <= seed[31:16];
    wt <= seed[1:0];
    for (int i = 0; i < 4; i++) net_q.push_back(16'h0100 + 16'(2 * i) ^ 16'h5A3C);
    @(posedge mclk_in) {local_load_in, local_req_in} <= 2'h1;
    fork
      begin
        n = 0;
        do begin @(posedge mclk_in); #1; n++; end while (bus_req_out !== 1'b1 && n < 50);
        do begin @(posedge mclk_in); #1; n++; end while (bus_req_out !== 1'b0 && n < 400);
        @(posedge mclk_in) local_req_in <= 1'b0;
      end
      begin
        repeat (4) @(posedge mclk_in);
        reg_acc(1'b0, 4'h6, 1'b0, 1'b0);
      end
    join
    repeat (60) begin
      @(posedge mclk_in) seed = lfsr(seed);
      net_ready_in <= seed[0];
    end
    @(posedge mclk_in) net_ready_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    chk_word({15'h0, net_valid_out}, 16'h0);
    $display("test local burst done");
    // Two remote single transfers in byte mode after a late grant
    @(posedge mclk_in) {mode_word_in, gdly, wt, remote_addr_in, remote_count_in} <= {7'h0D, 16'h0233, 16'h2};
    remote_start_in <= 1'b1;
    mode_32bit_in <= 1'b0;
    port_q.push_back(16'h0233 ^ 16'h5A3C);
    port_q.push_back(16'h0234 ^ 16'h5A3C);
    @(posedge mclk_in) remote_start_in <= 1'b0;
    n = 0;
    do begin @(posedge mclk_in); #1; n++; end while ((port_q.size() > 0 || port_req_out !== 1'b0) && n < 800);
    repeat (10) @(posedge mclk_in);
    chk_word(16'(net_q.size() + port_q.size() + reg_q.size()), 16'h0);
    $display("test remote transfers done");
    give_verdict();
  end
endmodule : nic_host_bus_and_dma_interface_test
